// *** shared/bsd_pkg.sv ***
// Constants, field layouts and carrier types of the bridge secondary control decode.
// Assumes one clock domain and a plain register port with one-cycle strobes.
//
// What this block does
// - Fast back-to-back only when bit 7 set
// - Bit 6 drives downstream reset out
// - Mode 0: reads give all ones, writes dropped
// - Mode 1: PCI master abort gives UR
// - Mode 1: UR completion gives PCI target abort
// - Mode 1: posted write abort signals error
// - Bit 4 makes I/O bits 15:10 decode
// - Full decode matters only with display decode
// - Claim memory 000A0000h through 000BFFFFh downstream
// - Claim I/O 3B0h-3BBh, 3C0h-3DFh, upper zero
// - Refuse legacy display addresses going upstream
// - Display forwarding ignores alias bit and windows
// - Forwarding still needs command space enables
// - Display decode off: windows alone decide
package bsd_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] BSD_OFF_CMD = 8'h04;
  localparam logic [7:0] BSD_OFF_BCTL = 8'h3e;
  localparam logic [7:0] BSD_OFF_IRQ_STAT = 8'h80;
  localparam logic [7:0] BSD_OFF_IRQ_MASK = 8'h84;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BSD_CMD_IO_BIT = 0;
  localparam int BSD_CMD_MEM_BIT = 1;
  localparam int BSD_BC_VGA_BIT = 3;
  localparam int BSD_BC_LEGACY_DISPLAY_FULL_DECODE_BIT = 4;
  localparam int BSD_BC_MAM_BIT = 5;
  localparam int BSD_BC_SECONDARY_BUS_RESET_BIT = 6;
  localparam int BSD_BC_FBB_BIT = 7;
  localparam logic [15:0] BSD_CMD_RST = 16'h0000;
  localparam logic [15:0] BSD_CMD_WMASK = 16'h0003;
  localparam logic [15:0] BSD_BCTL_RST = 16'h0000;
  localparam logic [15:0] BSD_BCTL_WMASK = 16'h00f8;

  // Interrupt status bits: one per event.
  localparam int BSD_EV_W = 4;
  localparam int BSD_EV_MABORT = 0;
  localparam int BSD_EV_UR_CPL = 1;
  localparam int BSD_EV_PW_ERR = 2;
  localparam int BSD_EV_UP_REFUSE = 3;
  localparam logic [BSD_EV_W-1:0] BSD_EV_RST = 4'h0;

  // ----------------------------------------------------------------
  // Legacy display address ranges
  // ----------------------------------------------------------------
  localparam logic [31:0] BSD_VGA_MEM_LO = 32'h000a_0000;
  localparam logic [31:0] BSD_VGA_MEM_HI = 32'h000b_ffff;
  localparam logic [9:0] BSD_VGA_IO_A_LO = 10'h3b0;
  localparam logic [9:0] BSD_VGA_IO_A_HI = 10'h3bb;
  localparam logic [9:0] BSD_VGA_IO_B_LO = 10'h3c0;
  localparam logic [9:0] BSD_VGA_IO_B_HI = 10'h3df;
  localparam logic [31:0] BSD_ALL_ONES = 32'hffff_ffff;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // One address-phase request presented for decode.
  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_mem;
    logic win_hit;
    logic [31:0] addr;
  } bsd_req_t;

  // Termination report of a forwarded transaction.
  typedef struct packed {
    logic valid;
    logic is_read;
    logic is_posted;
  } bsd_term_t;

endpackage

// *** rtl/bsd_bridge_ctrl.sv ***
// Bridge control and legacy display decode for a PCI Express to PCI bridge.
// Assumes the base/limit logic reports window hits and the transaction engines
// report master aborts and unsupported request completions as one-cycle events.
`timescale 1ns/1ps
`default_nettype none
module bsd_bridge_ctrl
  import bsd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Downstream decode, primary to secondary
  input wire bsd_pkg::bsd_req_t dn_req,
  output logic dn_claim,
  // Upstream decode, secondary to primary
  input wire bsd_pkg::bsd_req_t up_req,
  output logic up_forward,
  output logic up_refused,
  // Master abort on PCI for a forwarded transaction
  input wire bsd_pkg::bsd_term_t pci_mabort,
  // Unsupported request completion from PCI Express
  input wire bsd_pkg::bsd_term_t pcie_ur_cpl,
  // Termination responses
  output logic ur_cpl_out,
  output logic target_abort_out,
  output logic read_ones_out,
  output logic [31:0] read_fill_data,
  output logic write_discard_out,
  output logic error_signal_out,
  // Secondary bus controls
  output logic back_to_back_enable,
  output logic downstream_reset_out,
  // Interrupt
  output logic irq
);
  import bsd_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Legacy display memory window.
  function automatic logic vga_mem_hit(input logic [31:0] a);
    vga_mem_hit = (a >= BSD_VGA_MEM_LO) && (a <= BSD_VGA_MEM_HI);
  endfunction

  // Legacy display I/O ports; aliases pass unless full decode is on.
  function automatic logic vga_io_hit(input logic [31:0] a, input logic full16);
    logic lo_ok;
    lo_ok = ((a[9:0] >= BSD_VGA_IO_A_LO) && (a[9:0] <= BSD_VGA_IO_A_HI)) ||
            ((a[9:0] >= BSD_VGA_IO_B_LO) && (a[9:0] <= BSD_VGA_IO_B_HI));
    vga_io_hit = (a[31:16] == 16'h0000) && lo_ok &&
                 (!full16 || (a[15:10] == 6'h00));
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0] cmd_r;
  logic [15:0] bctl_r;
  logic [BSD_EV_W-1:0] stat_r;
  logic [BSD_EV_W-1:0] mask_r;
  logic [BSD_EV_W-1:0] ev_set;
  logic io_en;
  logic mem_en;
  logic vga_en;
  logic full16;
  logic abort_report_mode;
  logic dn_vga;
  logic dn_win;
  logic up_vga;

  assign io_en = cmd_r[BSD_CMD_IO_BIT];
  assign mem_en = cmd_r[BSD_CMD_MEM_BIT];
  assign vga_en = bctl_r[BSD_BC_VGA_BIT];
  // Full decode is only consulted inside the display decode path.
  assign full16 = bctl_r[BSD_BC_LEGACY_DISPLAY_FULL_DECODE_BIT];
  assign abort_report_mode = bctl_r[BSD_BC_MAM_BIT];

  // Command space enables; only the two enable bits are stored.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_r <= BSD_CMD_RST;
    end else if (reg_wr && reg_addr == BSD_OFF_CMD) begin
      cmd_r <= reg_wdata & BSD_CMD_WMASK;
    end
  end

  // Bridge control fields; a write lands before the next decode edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bctl_r <= BSD_BCTL_RST;
    end else if (reg_wr && reg_addr == BSD_OFF_BCTL) begin
      bctl_r <= reg_wdata & BSD_BCTL_WMASK;
    end
  end

  // Interrupt mask.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_r <= BSD_EV_RST;
    end else if (reg_wr && reg_addr == BSD_OFF_IRQ_MASK) begin
      mask_r <= reg_wdata[BSD_EV_W-1:0];
    end
  end

  // Sticky status, cleared by a read; an event in the clearing cycle survives.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stat_r <= BSD_EV_RST;
    end else if (reg_rd && reg_addr == BSD_OFF_IRQ_STAT) begin
      stat_r <= ev_set;
    end else begin
      stat_r <= stat_r | ev_set;
    end
  end

  // Read data, valid only in the cycle after the strobe.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        BSD_OFF_CMD: reg_rdata <= cmd_r;
        BSD_OFF_BCTL: reg_rdata <= bctl_r;
        BSD_OFF_IRQ_STAT: reg_rdata <= {12'h000, stat_r};
        BSD_OFF_IRQ_MASK: reg_rdata <= {12'h000, mask_r};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Level interrupt from any unmasked status bit.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((stat_r | ev_set) & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Secondary bus controls
  // ----------------------------------------------------------------

  // Registered copies keep the pins glitch free after a config write.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      back_to_back_enable <= 1'b0;
      downstream_reset_out <= 1'b0;
    end else begin
      back_to_back_enable <= bctl_r[BSD_BC_FBB_BIT];
      downstream_reset_out <= bctl_r[BSD_BC_SECONDARY_BUS_RESET_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Downstream display hits bypass the alias bit and the base/limit windows, but not
  // the command space enables.
  assign dn_vga = vga_en && ((dn_req.is_io && io_en && vga_io_hit(dn_req.addr, full16)) ||
                  (dn_req.is_mem && mem_en && vga_mem_hit(dn_req.addr)));
  assign dn_win = (dn_req.is_io && io_en && dn_req.win_hit) ||
                  (dn_req.is_mem && mem_en && dn_req.win_hit);
  assign up_vga = vga_en && ((up_req.is_io && vga_io_hit(up_req.addr, full16)) ||
                  (up_req.is_mem && vga_mem_hit(up_req.addr)));

  // Downstream claim.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dn_claim <= 1'b0;
    end else begin
      dn_claim <= dn_req.valid && (dn_vga || dn_win);
    end
  end

  // Upstream forwarding: addresses owned downstream never go up.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      up_forward <= 1'b0;
      up_refused <= 1'b0;
    end else begin
      up_forward <= up_req.valid && !up_req.win_hit && !up_vga;
      up_refused <= up_req.valid && !up_req.win_hit && up_vga;
    end
  end

  // ----------------------------------------------------------------
  // Abort reporting
  // ----------------------------------------------------------------

  // Events for the status register.
  always_comb begin
    ev_set = BSD_EV_RST;
    ev_set[BSD_EV_MABORT] = pci_mabort.valid;
    ev_set[BSD_EV_UR_CPL] = pcie_ur_cpl.valid;
    ev_set[BSD_EV_PW_ERR] = pci_mabort.valid && pci_mabort.is_posted && abort_report_mode;
    ev_set[BSD_EV_UP_REFUSE] = up_req.valid && !up_req.win_hit && up_vga;
  end

  // Mode 1 reports the abort in the other protocol; mode 0 hides it with
  // all-ones read data and a silent write drop.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ur_cpl_out <= 1'b0;
      target_abort_out <= 1'b0;
      error_signal_out <= 1'b0;
      read_ones_out <= 1'b0;
      write_discard_out <= 1'b0;
      read_fill_data <= 32'h0000_0000;
    end else begin
      ur_cpl_out <= pci_mabort.valid && abort_report_mode;
      target_abort_out <= pcie_ur_cpl.valid && abort_report_mode;
      error_signal_out <= pci_mabort.valid && pci_mabort.is_posted && abort_report_mode;
      read_ones_out <= !abort_report_mode && ((pci_mabort.valid && pci_mabort.is_read) ||
                       (pcie_ur_cpl.valid && pcie_ur_cpl.is_read));
      write_discard_out <= !abort_report_mode && ((pci_mabort.valid && !pci_mabort.is_read) ||
                           (pcie_ur_cpl.valid && !pcie_ur_cpl.is_read));
      read_fill_data <= BSD_ALL_ONES;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_fbb_follows_bit: assert property (
    reg_wr && reg_addr == BSD_OFF_BCTL |=> ##1
      back_to_back_enable == $past(reg_wdata[BSD_BC_FBB_BIT], 2))
    else $error("back to back enable does not follow its field");
  a_reset_out_level: assert property (
    reg_wr && reg_addr == BSD_OFF_BCTL && reg_wdata[BSD_BC_SECONDARY_BUS_RESET_BIT] ##1 !reg_wr [*2] |->
      downstream_reset_out)
    else $error("downstream reset not asserted");
  a_mode0_hides_abort: assert property (
    pci_mabort.valid && !abort_report_mode |=> !ur_cpl_out && !error_signal_out &&
      ($past(pci_mabort.is_read) ? read_ones_out : write_discard_out))
    else $error("mode 0 abort not hidden");
  a_mode1_ur_cpl: assert property (
    pci_mabort.valid && abort_report_mode |=> ur_cpl_out)
    else $error("master abort did not give UR completion");
  a_mode1_tabort: assert property (
    $rose(target_abort_out) |-> $past(pcie_ur_cpl.valid) && $past(abort_report_mode))
    else $error("target abort without cause");
  a_posted_error: assert property (
    error_signal_out |-> $past(pci_mabort.is_posted) && ur_cpl_out)
    else $error("error signal without posted abort");
  a_alias_decode: assert property (
    dn_req.valid && dn_req.is_io && io_en && vga_en && full16 && !dn_req.win_hit &&
      dn_req.addr[15:10] != 6'h00 |=> !dn_claim)
    else $error("alias claimed under full decode");
  a_vga_mem_claim: assert property (
    dn_req.valid && dn_req.is_mem && mem_en && vga_en &&
      dn_req.addr == BSD_VGA_MEM_HI |=> dn_claim)
    else $error("display memory not claimed");
  a_io_needs_enable: assert property (
    dn_req.valid && dn_req.is_io && !dn_req.is_mem && !io_en |=> !dn_claim)
    else $error("I/O claimed with space disabled");
  a_up_refuse: assert property (
    up_refused |-> !up_forward && stat_r[BSD_EV_UP_REFUSE])
    else $error("upstream display access not refused");

  c_vga_io_claim: cover property (dn_req.valid && dn_req.is_io && vga_en ##1 dn_claim);
  c_mode1_abort: cover property (pci_mabort.valid && abort_report_mode ##1 ur_cpl_out ##1 irq);
  c_secondary_bus_reset_cycle: cover property ($rose(downstream_reset_out) ##[1:20] $fell(downstream_reset_out));
endmodule
`default_nettype wire

// *** tb/bsd_far_side.sv ***
// Far-side model: PCI transaction engine and PCI Express receiver reports.
// Assumes the bench raises one command for one cycle per event.
`timescale 1ns/1ps
`default_nettype none
module bsd_far_side
  import bsd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Commands from the bench
  input wire logic go_mabort,
  input wire logic go_ur,
  input wire bsd_pkg::bsd_term_t kind,
  // Termination reports toward the bridge
  output var bsd_pkg::bsd_term_t pci_mabort,
  output var bsd_pkg::bsd_term_t pcie_ur_cpl
);
  import bsd_pkg::*;

  // Reports are one-cycle pulses, since a held report would be taken twice.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pci_mabort <= '0;
      pcie_ur_cpl <= '0;
    end else begin
      pci_mabort <= go_mabort ? kind : '0;
      pcie_ur_cpl <= go_ur ? kind : '0;
    end
  end
endmodule
`default_nettype wire

// *** tb/bsd_bridge_ctrl_bench.sv ***
// Self-checking bench for the bridge control and legacy display decode.
// Assumes bsd_pkg, the design and the far-side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bsd_bridge_ctrl_bench;
  import bsd_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys, rst, reg_wr, reg_rd, go_mabort, go_ur, dn_claim, up_forward, up_refused;
  logic ur_cpl_out, target_abort_out, read_ones_out, write_discard_out, error_signal_out;
  logic back_to_back_enable, downstream_reset_out, irq;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [31:0] read_fill_data;
  bsd_req_t dn_req, up_req;
  bsd_term_t kind, pci_mabort, pcie_ur_cpl;
  int error_cnt, check_count;
  typedef struct packed {
    logic [7:0] bctl;
    logic [1:0] cmd;
    logic io;
    logic win;
    logic [31:0] addr;
    logic exp;
  } bsd_row_t;
  // Downstream decode cases: control, command enables, request and expected claim.
  bsd_row_t rows [0:18] = '{
    '{8'h08, 2'h3, 1'b0, 1'b0, 32'h000a_0000, 1'b1}, '{8'h08, 2'h3, 1'b0, 1'b0, 32'h000b_ffff, 1'b1},
    '{8'h08, 2'h3, 1'b0, 1'b0, 32'h000c_0000, 1'b0}, '{8'h08, 2'h3, 1'b0, 1'b0, 32'h0009_ffff, 1'b0},
    '{8'h08, 2'h1, 1'b0, 1'b0, 32'h000a_0000, 1'b0}, '{8'h08, 2'h3, 1'b1, 1'b0, 32'h0000_03b0, 1'b1},
    '{8'h08, 2'h3, 1'b1, 1'b0, 32'h0000_03bb, 1'b1}, '{8'h08, 2'h3, 1'b1, 1'b0, 32'h0000_03bc, 1'b0},
    '{8'h08, 2'h3, 1'b1, 1'b0, 32'h0000_03df, 1'b1}, '{8'h08, 2'h3, 1'b1, 1'b0, 32'h0000_03af, 1'b0},
    '{8'h08, 2'h3, 1'b1, 1'b0, 32'h0001_03c0, 1'b0}, '{8'h08, 2'h2, 1'b1, 1'b0, 32'h0000_03c0, 1'b0},
    '{8'h08, 2'h3, 1'b1, 1'b0, 32'h0000_fbc0, 1'b1}, '{8'h18, 2'h3, 1'b1, 1'b0, 32'h0000_fbc0, 1'b0},
    '{8'h18, 2'h3, 1'b1, 1'b0, 32'h0000_03c0, 1'b1}, '{8'h00, 2'h3, 1'b0, 1'b0, 32'h000a_0000, 1'b0},
    '{8'h00, 2'h3, 1'b0, 1'b1, 32'h000a_0000, 1'b1}, '{8'h10, 2'h3, 1'b1, 1'b0, 32'h0000_fbc0, 1'b0},
    '{8'h10, 2'h3, 1'b1, 1'b1, 32'h0000_fbc0, 1'b1}};

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  bsd_bridge_ctrl u_bsd_bridge_ctrl (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dn_req(dn_req), .dn_claim(dn_claim), .up_req(up_req), .up_forward(up_forward),
    .up_refused(up_refused), .pci_mabort(pci_mabort), .pcie_ur_cpl(pcie_ur_cpl),
    .ur_cpl_out(ur_cpl_out), .target_abort_out(target_abort_out),
    .read_ones_out(read_ones_out), .read_fill_data(read_fill_data),
    .write_discard_out(write_discard_out), .error_signal_out(error_signal_out),
    .back_to_back_enable(back_to_back_enable), .downstream_reset_out(downstream_reset_out),
    .irq(irq));
  bsd_far_side u_bsd_far_side (.clk_sys(clk_sys), .rst(rst), .go_mabort(go_mabort),
    .go_ur(go_ur), .kind(kind), .pci_mabort(pci_mabort), .pcie_ur_cpl(pcie_ur_cpl));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  // Register strobes last one cycle; the next access waits for a fresh edge.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk_word({16'h0, reg_rdata}, {16'h0, exp});
  endtask
  task automatic req(input logic up, input logic io, input logic win, input logic [31:0] a);
    @(posedge clk_sys);
    if (up) up_req <= '{1'b1, io, !io, win, a};
    else dn_req <= '{1'b1, io, !io, win, a};
    @(posedge clk_sys);
    dn_req <= '0;
    up_req <= '0;
    #1;
  endtask
  // The model needs one edge, the bridge one more, so results show two edges on.
  task automatic term(input logic ab, input logic ur, input logic rdx, input logic po,
                      input logic [4:0] exp);
    @(posedge clk_sys);
    go_mabort <= ab;
    go_ur <= ur;
    kind <= '{1'b1, rdx, po};
    @(posedge clk_sys);
    go_mabort <= 1'b0;
    go_ur <= 1'b0;
    @(posedge clk_sys);
    #1 chk_word({27'h0, ur_cpl_out, target_abort_out, read_ones_out, write_discard_out,
                 error_signal_out}, {27'h0, exp});
  endtask
  task automatic end_of_test();
    $display("mismatches %0d, comparisons %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // The run needs about 200 cycles; over thirty times that means a hang.
  initial begin
    #300_000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    {rst, reg_wr, reg_rd, go_mabort, go_ur, reg_addr, reg_wdata} = '0;
    rst = 1'b1;
    {dn_req, up_req, kind, error_cnt, check_count} = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1 chk_bit(back_to_back_enable, 1'b0);
    chk_bit(downstream_reset_out, 1'b0);
    rd(BSD_OFF_BCTL, 16'h0000);
    rd(BSD_OFF_CMD, 16'h0000);
    rd(8'h40, 16'h0000);
    wr(BSD_OFF_BCTL, 16'hffff);
    rd(BSD_OFF_BCTL, 16'h00f8);
    wr(BSD_OFF_BCTL, 16'h0080);
    @(posedge clk_sys);
    #1 chk_bit(back_to_back_enable, 1'b1);
    chk_bit(downstream_reset_out, 1'b0);
    wr(BSD_OFF_BCTL, 16'h0040);
    @(posedge clk_sys);
    #1 chk_bit(back_to_back_enable, 1'b0);
    chk_bit(downstream_reset_out, 1'b1);
    foreach (rows[i]) begin
      wr(BSD_OFF_BCTL, {8'h00, rows[i].bctl});
      wr(BSD_OFF_CMD, {14'h0, rows[i].cmd});
      req(1'b0, rows[i].io, rows[i].win, rows[i].addr);
      chk_bit(dn_claim, rows[i].exp);
    end
    // Upstream: display addresses are held back only while display decode is on.
    wr(BSD_OFF_BCTL, 16'h0008);
    req(1'b1, 1'b0, 1'b0, 32'h000a_0000);
    chk_bit(up_refused, 1'b1);
    chk_bit(up_forward, 1'b0);
    req(1'b1, 1'b1, 1'b0, 32'h0000_03c0);
    chk_bit(up_refused, 1'b1);
    wr(BSD_OFF_BCTL, 16'h0000);
    req(1'b1, 1'b0, 1'b0, 32'h000a_0000);
    chk_bit(up_forward, 1'b1);
    chk_bit(up_refused, 1'b0);
    // Terminations in both reporting modes.
    term(1'b1, 1'b0, 1'b1, 1'b0, 5'b00100);
    chk_word(read_fill_data, BSD_ALL_ONES);
    term(1'b1, 1'b0, 1'b0, 1'b1, 5'b00010);
    wr(BSD_OFF_BCTL, 16'h0020);
    term(1'b1, 1'b0, 1'b0, 1'b1, 5'b10001);
    term(1'b1, 1'b0, 1'b1, 1'b0, 5'b10000);
    term(1'b0, 1'b1, 1'b1, 1'b0, 5'b01000);
    // Interrupt: sticky status, cleared by read, gated by the mask.
    rd(BSD_OFF_IRQ_STAT, 16'h000f);
    rd(BSD_OFF_IRQ_STAT, 16'h0000);
    wr(BSD_OFF_IRQ_MASK, 16'h0004);
    term(1'b1, 1'b0, 1'b0, 1'b1, 5'b10001);
    chk_bit(irq, 1'b1);
    rd(BSD_OFF_IRQ_STAT, 16'h0005);
    @(posedge clk_sys);
    #1 chk_bit(irq, 1'b0);
    term(1'b0, 1'b1, 1'b0, 1'b0, 5'b01000);
    chk_bit(irq, 1'b0);
    rd(BSD_OFF_IRQ_STAT, 16'h0002);
    // Reset in mid-run: every field and pin must fall back to its idle value.
    wr(BSD_OFF_BCTL, 16'h00e8);
    wr(BSD_OFF_CMD, 16'h0003);
    @(posedge clk_sys);
    #1 chk_bit(back_to_back_enable, 1'b1);
    chk_bit(downstream_reset_out, 1'b1);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1 chk_bit(back_to_back_enable, 1'b0);
    chk_bit(downstream_reset_out, 1'b0);
    chk_bit(irq, 1'b0);
    // Space enables are cleared too, so even a window hit is not claimed.
    req(1'b0, 1'b0, 1'b1, 32'h000a_0000);
    chk_bit(dn_claim, 1'b0);
    rd(BSD_OFF_BCTL, 16'h0000);
    rd(BSD_OFF_IRQ_MASK, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
